// File: hdl/llsd_det_if.sv
// Purpose: Carries the retimed line bits to the digital detector and its verdict back
// Assumes: Same clock on both ends
// Notes:   No clocking block; pure wiring between top and detector
`timescale 1ns/100ps

interface llsd_det_if;
  logic bit_valid;
  logic pulse;
  logic enable;
  logic los;

  modport top (output bit_valid, output pulse, output enable, input  los);
  modport det (input  bit_valid, input  pulse, input  enable, output los);
endinterface : llsd_det_if

// File: hdl/llsd_dig_det.sv
// Purpose: Digital loss-of-signal detector: zero-run declare, pulse-density clear
// Assumes: One bit period per bit_valid strobe, pulse marks a mark in that bit
// Notes:   Density is measured in fixed windows only while declaring
`timescale 1ns/100ps

module llsd_dig_det
  import llsd_pkg::*;
#(
  parameter int unsigned RUN_LEN = ZERO_RUN_DECLARE,
  parameter int unsigned WIN     = DENSITY_WIN,
  parameter int unsigned PCT     = DENSITY_PCT
) (
  // Clock and reset
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  // Line side
  llsd_det_if.det   det
);
  import llsd_pkg::*;

  localparam int unsigned RUN_W = $clog2(RUN_LEN + 1);
  localparam int unsigned WIN_W = $clog2(WIN + 1);
  // Least pulse count in a window that gives the required density, rounded up
  localparam logic [WIN_W-1:0] DENS_MIN = WIN_W'((PCT * WIN + 99) / 100);
  localparam logic [RUN_W-1:0] RUN_LAST = RUN_W'(RUN_LEN - 1);
  localparam logic [WIN_W-1:0] WIN_LAST = WIN_W'(WIN - 1);

  llsd_dig_e         state;
  llsd_dig_e         next_state;
  logic [RUN_W-1:0]  run_cnt;
  logic [RUN_W-1:0]  next_run_cnt;
  logic [WIN_W-1:0]  win_cnt;
  logic [WIN_W-1:0]  next_win_cnt;
  logic [WIN_W-1:0]  pulse_cnt;
  logic [WIN_W-1:0]  next_pulse_cnt;

  // ==========================================================================
  // Next state
  always_comb begin
    logic [WIN_W-1:0] total;
    total          = pulse_cnt + WIN_W'(det.pulse);
    next_state     = state;
    next_run_cnt   = run_cnt;
    next_win_cnt   = win_cnt;
    next_pulse_cnt = pulse_cnt;
    if (!det.enable) begin
      next_state     = DIG_CLEAR;
      next_run_cnt   = '0;
      next_win_cnt   = '0;
      next_pulse_cnt = '0;
    end else if (det.bit_valid) begin
      if (det.pulse) begin
        next_run_cnt = '0;
      end else if (run_cnt != RUN_W'(RUN_LEN)) begin
        next_run_cnt = run_cnt + RUN_W'(1);
      end
      case (state)
        DIG_CLEAR: begin
          if (!det.pulse && run_cnt == RUN_LAST) begin
            next_state     = DIG_LOS;
            next_win_cnt   = '0;
            next_pulse_cnt = '0;
          end
        end
        DIG_LOS: begin
          if (win_cnt == WIN_LAST) begin
            next_win_cnt   = '0;
            next_pulse_cnt = '0;
            if (total >= DENS_MIN) begin
              next_state = DIG_CLEAR;
            end
          end else begin
            next_win_cnt   = win_cnt + WIN_W'(1);
            next_pulse_cnt = total;
          end
        end
        default: next_state = DIG_CLEAR;
      endcase
    end
  end

  // ==========================================================================
  // Registers
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      state     <= DIG_CLEAR;
      run_cnt   <= '0;
      win_cnt   <= '0;
      pulse_cnt <= '0;
    end else begin
      state     <= next_state;
      run_cnt   <= next_run_cnt;
      win_cnt   <= next_win_cnt;
      pulse_cnt <= next_pulse_cnt;
    end
  end

  assign det.los = (state == DIG_LOS);

endmodule : llsd_dig_det

// File: hdl/llsd_pkg.sv
// Purpose: Shared constants and types for the line loss-of-signal detect block
// Assumes: One channel per instance, registers on AXI4-Lite with 32-bit data
// Notes:   Every offset, field position, reset value and count lives here
package llsd_pkg;

  // ==========================================================================
  // Register map
  localparam int unsigned ADDR_W     = 4;
  localparam logic [3:0]  OFF_CTRL   = 4'h0;
  localparam logic [3:0]  OFF_STATUS = 4'h4;

  // Control register fields
  localparam int unsigned CTRL_MODE_LSB = 0;
  localparam logic [1:0]  MODE_DS3      = 2'h0;
  localparam logic [1:0]  MODE_STS1     = 2'h1;
  localparam logic [1:0]  MODE_E3       = 2'h2;
  localparam logic [1:0]  CTRL_RESET    = 2'h0;

  // Status register fields
  localparam int unsigned STAT_DIG_BIT = 5;
  localparam int unsigned STAT_ANA_BIT = 4;
  localparam int unsigned STAT_LOS_BIT = 1;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ==========================================================================
  // Digital detector counts, in bit periods and percent
  localparam int unsigned ZERO_RUN_DECLARE = 160;
  localparam int unsigned DENSITY_WIN      = 32;
  localparam int unsigned DENSITY_PCT      = 33;

  typedef enum logic [0:0] {
    DIG_CLEAR = 1'b0,
    DIG_LOS   = 1'b1
  } llsd_dig_e;

endpackage : llsd_pkg

// File: hdl/llsd_top.sv
// Purpose: One channel of line loss-of-signal detection with AXI4-Lite status access
// Assumes: Line bits arrive retimed to i_clk with a per-bit strobe; comparator
//          outputs and the E3 detector flag are handled as noted at the ports
// Notes:   Notes on behaviour below
`timescale 1ns/100ps

module llsd_top
  import llsd_pkg::*;
(
  // Clock and reset
  input  wire logic                  i_clk,
  input  wire logic                  i_rst_n,
  // Retimed line bits, same clock
  input  wire logic                  i_rx_bit_valid,
  input  wire logic                  i_rx_pulse,
  // Amplitude comparators, asynchronous pins
  input  wire logic                  i_amp_below_declare,
  input  wire logic                  i_amp_above_clear,
  // E3 detector verdict, same clock
  input  wire logic                  i_e3_los,
  // Channel loss flag
  output logic                       o_los,
  // AXI4-Lite write address and data
  input  wire logic [llsd_pkg::ADDR_W-1:0] i_awaddr,
  input  wire logic                  i_awvalid,
  output logic                       o_awready,
  input  wire logic [31:0]           i_wdata,
  input  wire logic [3:0]            i_wstrb,
  input  wire logic                  i_wvalid,
  output logic                       o_wready,
  output logic [1:0]                 o_bresp,
  output logic                       o_bvalid,
  input  wire logic                  i_bready,
  // AXI4-Lite read
  input  wire logic [llsd_pkg::ADDR_W-1:0] i_araddr,
  input  wire logic                  i_arvalid,
  output logic                       o_arready,
  output logic [31:0]                o_rdata,
  output logic [1:0]                 o_rresp,
  output logic                       o_rvalid,
  input  wire logic                  i_rready
);
  import llsd_pkg::*;

  llsd_det_if det_bus ();

  logic [1:0]        amp_sync;
  logic [1:0]        next_amp_sync;
  logic              clr_sync0;
  logic              clr_sync1;
  logic              ana_los;
  logic              next_ana_los;
  logic              los;
  logic              next_los;
  logic [1:0]        mode;
  logic [1:0]        next_mode;
  logic              aw_ok;
  logic              next_aw_ok;
  logic              w_ok;
  logic              next_w_ok;
  logic [ADDR_W-1:0] aw_addr;
  logic [ADDR_W-1:0] next_aw_addr;
  logic [31:0]       w_data;
  logic [31:0]       next_w_data;
  logic [3:0]        w_strb;
  logic [3:0]        next_w_strb;
  logic              awready;
  logic              next_awready;
  logic              wready;
  logic              next_wready;
  logic              bvalid;
  logic              next_bvalid;
  logic [1:0]        bresp;
  logic [1:0]        next_bresp;
  logic              arready;
  logic              next_arready;
  logic              rvalid;
  logic              next_rvalid;
  logic [1:0]        rresp;
  logic [1:0]        next_rresp;
  logic [31:0]       rdata;
  logic [31:0]       next_rdata;
  logic              line_mode;

  // ==========================================================================
  // Digital detector, idle in E3 mode
  assign line_mode         = (mode != MODE_E3);
  assign det_bus.bit_valid = i_rx_bit_valid;
  assign det_bus.pulse     = i_rx_pulse;
  assign det_bus.enable    = line_mode;

  llsd_dig_det u_dig (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .det     (det_bus)
  );

  // ==========================================================================
  // Analog detector and channel flag
  always_comb begin
    // Stage 0 feeds only stage 1
    next_amp_sync = {amp_sync[0], i_amp_below_declare};
    next_ana_los  = ana_los;
    if (!line_mode) begin
      next_ana_los = 1'b0;
    end else if (amp_sync[1]) begin
      next_ana_los = 1'b1;
    end else if (clr_sync1) begin
      // Only the upper level releases, so noise between levels holds state
      next_ana_los = 1'b0;
    end
    next_los = det_bus.los | ana_los
             | ((mode == MODE_E3) & i_e3_los);
  end

  // ==========================================================================
  // AXI4-Lite slave; one write and one read in flight, read answer one cycle later, write answer two
  always_comb begin
    next_mode    = mode;
    next_aw_ok   = aw_ok;
    next_w_ok    = w_ok;
    next_aw_addr = aw_addr;
    next_w_data  = w_data;
    next_w_strb  = w_strb;
    next_bvalid  = bvalid;
    next_bresp   = bresp;
    next_rvalid  = rvalid;
    next_rresp   = rresp;
    next_rdata   = rdata;
    if (i_awvalid && awready) begin
      next_aw_ok   = 1'b1;
      next_aw_addr = i_awaddr;
    end
    if (i_wvalid && wready) begin
      next_w_ok   = 1'b1;
      next_w_data = i_wdata;
      next_w_strb = i_wstrb;
    end
    if (bvalid && i_bready) begin
      next_bvalid = 1'b0;
    end
    if (aw_ok && w_ok && !bvalid) begin
      next_aw_ok  = 1'b0;
      next_w_ok   = 1'b0;
      next_bvalid = 1'b1;
      next_bresp  = RESP_OKAY;
      if (aw_addr == OFF_CTRL) begin
        if (w_strb[0]) begin
          next_mode = w_data[CTRL_MODE_LSB +: 2];
        end
      end else if (aw_addr != OFF_STATUS) begin
        next_bresp = RESP_SLVERR;
      end
    end
    if (rvalid && i_rready) begin
      next_rvalid = 1'b0;
    end
    if (i_arvalid && arready) begin
      next_rvalid = 1'b1;
      next_rresp  = RESP_OKAY;
      next_rdata  = 32'h0000_0000;
      case (i_araddr)
        OFF_CTRL:   next_rdata[CTRL_MODE_LSB +: 2] = mode;
        OFF_STATUS: begin
          next_rdata[STAT_DIG_BIT] = det_bus.los;
          next_rdata[STAT_ANA_BIT] = ana_los;
          next_rdata[STAT_LOS_BIT] = los;
        end
        default:    next_rresp = RESP_SLVERR;
      endcase
    end
    next_awready = !next_aw_ok && !next_bvalid;
    next_wready  = !next_w_ok && !next_bvalid;
    next_arready = !next_rvalid;
  end

  // ==========================================================================
  // Registers
  always_ff @(posedge i_clk) begin
    clr_sync0 <= i_amp_above_clear;
    clr_sync1 <= clr_sync0;
    if (!i_rst_n) begin
      amp_sync <= 2'h0;
      ana_los  <= 1'b0;
      los      <= 1'b0;
      mode     <= CTRL_RESET;
      aw_ok    <= 1'b0;
      w_ok     <= 1'b0;
      aw_addr  <= '0;
      w_data   <= 32'h0000_0000;
      w_strb   <= 4'h0;
      awready  <= 1'b0;
      wready   <= 1'b0;
      bvalid   <= 1'b0;
      bresp    <= RESP_OKAY;
      arready  <= 1'b0;
      rvalid   <= 1'b0;
      rresp    <= RESP_OKAY;
      rdata    <= 32'h0000_0000;
    end else begin
      amp_sync <= next_amp_sync;
      ana_los  <= next_ana_los;
      los      <= next_los;
      mode     <= next_mode;
      aw_ok    <= next_aw_ok;
      w_ok     <= next_w_ok;
      aw_addr  <= next_aw_addr;
      w_data   <= next_w_data;
      w_strb   <= next_w_strb;
      awready  <= next_awready;
      wready   <= next_wready;
      bvalid   <= next_bvalid;
      bresp    <= next_bresp;
      arready  <= next_arready;
      rvalid   <= next_rvalid;
      rresp    <= next_rresp;
      rdata    <= next_rdata;
    end
  end

  assign o_los     = los;
  assign o_awready = awready;
  assign o_wready  = wready;
  assign o_bvalid  = bvalid;
  assign o_bresp   = bresp;
  assign o_arready = arready;
  assign o_rvalid  = rvalid;
  assign o_rresp   = rresp;
  assign o_rdata   = rdata;

endmodule : llsd_top

// File: sim/llsd_line_model.sv
// Purpose: Line-side stand-in: received bits and amplitude comparators
// Assumes: Bench asks for at most one bit per cycle
// Notes:   Comparator pins move a few ns off the clock, like async inputs
`timescale 1ns/100ps

module llsd_line_model (
  // Requests from the bench
  input  wire logic i_clk,
  input  wire logic i_send,
  input  wire logic i_mark,
  input  wire logic i_low,
  input  wire logic i_high,
  // Line side
  output logic      o_bit_valid = 1'b0,
  output logic      o_pulse     = 1'b0,
  output logic      o_below,
  output logic      o_above
);
  // ==========================================================================
  // Outside a bit the data line toggles, so a stale level is never trusted
  always @(posedge i_clk) begin
    o_bit_valid <= i_send;
    o_pulse     <= i_send ? i_mark : ~o_pulse;
  end
  assign #7 o_below = i_low;
  assign #7 o_above = i_high;
endmodule : llsd_line_model

// File: sim/llsd_top_sva.sv
// Purpose: Port-level assertions for llsd_top
// Assumes: Write address and data are taken at one edge
// Notes:   Mode and the zero run are shadowed from the ports
`timescale 1ns/100ps

module llsd_top_sva
  import llsd_pkg::*;
(
  // Clock and reset
  input wire logic        i_clk,
  input wire logic        i_rst_n,
  // Line and detector inputs
  input wire logic        i_rx_bit_valid,
  input wire logic        i_rx_pulse,
  input wire logic        i_amp_below_declare,
  input wire logic        i_e3_los,
  input wire logic        o_los,
  // Register bus
  input wire logic [3:0]  i_awaddr,
  input wire logic        i_awvalid,
  input wire logic        o_awready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0]  i_wstrb,
  input wire logic        i_wvalid,
  input wire logic        o_wready,
  input wire logic [1:0]  o_bresp,
  input wire logic        o_bvalid,
  input wire logic        i_bready,
  input wire logic [3:0]  i_araddr,
  input wire logic        i_arvalid,
  input wire logic        o_arready,
  input wire logic [31:0] o_rdata,
  input wire logic        o_rvalid,
  input wire logic        i_rready
);
  logic [1:0] mode;
  logic [1:0] next_mode;
  logic [7:0] run;
  logic [7:0] next_run;
  logic       wr_ok;
  logic       wr_ctrl;
  logic       next_wr_ctrl;
  logic [1:0] wr_mode;
  logic [1:0] next_wr_mode;
  assign wr_ok = i_awvalid && o_awready && i_wvalid && o_wready;
  // ==========================================================================
  // Shadow state
  always_comb begin
    next_mode    = mode;
    next_run     = run;
    next_wr_ctrl = wr_ok && i_awaddr == OFF_CTRL && i_wstrb[0];
    next_wr_mode = i_wdata[1:0];
    // The mode lands one edge after the bus takes the write
    if (wr_ctrl) begin
      next_mode = wr_mode;
    end
    // Saturates so a long silence never wraps back to a short run
    if (mode == MODE_E3) begin
      next_run = 8'h0;
    end else if (i_rx_bit_valid) begin
      next_run = i_rx_pulse ? 8'h0 : run + ((run != 8'hff) ? 8'h1 : 8'h0);
    end
  end
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      mode    <= MODE_DS3;
      run     <= 8'h0;
      wr_ctrl <= 1'b0;
      wr_mode <= MODE_DS3;
    end else begin
      mode    <= next_mode;
      run     <= next_run;
      wr_ctrl <= next_wr_ctrl;
      wr_mode <= next_wr_mode;
    end
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  dig_declare_a: assert property (run == 8'd159 && i_rx_bit_valid && !i_rx_pulse
    && mode != MODE_E3 |-> ##2 o_los) else $error("zero run did not raise loss");
  ana_declare_a: assert property ((i_amp_below_declare && mode != MODE_E3) [*4]
    |=> o_los) else $error("low amplitude did not raise loss");
  e3_flag_a: assert property (mode == MODE_E3 && i_e3_los |=> o_los)
    else $error("e3 loss not passed to flag");
  e3_quiet_a: assert property ((mode == MODE_E3 && !i_e3_los) [*3] |=> !o_los)
    else $error("loss flag set in e3 mode without e3 loss");
  status_los_a: assert property (i_arvalid && o_arready && i_araddr == OFF_STATUS
    |=> o_rdata[STAT_LOS_BIT] == $past(o_los)) else $error("status bit 1 differs from flag");
  b_answer_a: assert property (wr_ok |=> !o_awready && !o_wready ##1 o_bvalid)
    else $error("write answer late");
  r_answer_a: assert property (i_arvalid && o_arready |=> o_rvalid && !o_arready)
    else $error("read answer late");
  b_hold_a: assert property (o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp))
    else $error("write response dropped");
  r_hold_a: assert property (o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata))
    else $error("read data dropped");
endmodule : llsd_top_sva

bind llsd_top llsd_top_sva u_sva (.*);

// File: sim/test_llsd_top.sv
// Purpose: Self-checking bench for llsd_top
// Assumes: Line model delivers each bit one cycle after the request
// Notes:   Status reads and the flag are compared with an integer model
`timescale 1ns/100ps

module test_llsd_top;
  import llsd_pkg::*;
  logic        clk = 0, rst_n = 0, send = 0, mark = 0, lo = 0, hi = 0, e3 = 0;
  logic        bv, pl, bl, ab, los, awready, wready, bvalid, arready, rvalid;
  logic [3:0]  awaddr = 0, araddr = 0, wstrb = 4'hf;
  logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [31:0] wdata = 0, d, rdata;
  logic [1:0]  r, bresp, rresp;
  logic [31:0] lfsr = 78201;
  int          err_total = 0, total_checks = 0;
  int          m_dig = 0, m_ana = 0, m_mode = 0, m_run = 0, m_win = 0, m_pul = 0;
  always #25 clk = ~clk;
  llsd_line_model line (.i_clk(clk), .i_send(send), .i_mark(mark), .i_low(lo),
    .i_high(hi), .o_bit_valid(bv), .o_pulse(pl), .o_below(bl), .o_above(ab));
  llsd_top dut (.i_clk(clk), .i_rst_n(rst_n), .i_rx_bit_valid(bv), .i_rx_pulse(pl),
    .i_amp_below_declare(bl), .i_amp_above_clear(ab), .i_e3_los(e3), .o_los(los),
    .i_awaddr(awaddr), .i_awvalid(awvalid), .o_awready(awready), .i_wdata(wdata),
    .i_wstrb(wstrb), .i_wvalid(wvalid), .o_wready(wready), .o_bresp(bresp),
    .o_bvalid(bvalid), .i_bready(bready), .i_araddr(araddr), .i_arvalid(arvalid),
    .o_arready(arready), .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid),
    .i_rready(rready));
  // ==========================================================================
  // Tasks
  task automatic tally_and_finish;
    if (err_total == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : tally_and_finish
  function automatic logic [31:0] lfsr_next(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : lfsr_next
  task automatic chk(input logic [33:0] s, input logic [33:0] e);
    total_checks++;
    if (s !== e) begin
      err_total++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge clk);
    awaddr  <= a;
    wdata   <= v;
    awvalid <= 1;
    wvalid  <= 1;
    bready  <= 1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 0;
      if (wready) wvalid <= 0;
    end while (!(bvalid && bready));
    chk(bresp, RESP_OKAY);
    bready <= 0;
  endtask : wr
  task automatic rd(input logic [3:0] a);
    @(posedge clk);
    araddr  <= a;
    arvalid <= 1;
    rready  <= 1;
    do begin
      @(posedge clk);
      if (arready) arvalid <= 0;
    end while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 0;
  endtask : rd
  task automatic check_status;
    int l;
    repeat (6) @(posedge clk);
    l = m_dig | m_ana | (m_mode == 2 && e3);
    chk(los, l[0]);
    rd(OFF_STATUS);
    chk(d, {26'h0, m_dig[0], m_ana[0], 2'h0, l[0], 1'h0});
  endtask : check_status
  // Pattern k: pulses on the first k bits of each 32, or random when negative
  task automatic bits(input int n, input int k);
    logic p;
    for (int i = 0; i < n; i++) begin
      lfsr = lfsr_next(lfsr);
      p = (k < 0) ? (lfsr[1:0] == 2'h0) : ((i % 32) < k);
      @(posedge clk);
      send <= 1;
      mark <= p;
      // E3 mode holds the digital detector and its run counter clear
      m_run = (m_mode == 2 || p) ? 0 : m_run + 1;
      if (m_mode == 2) begin
        m_dig = 0;
      end else if (m_dig != 0) begin
        m_win++;
        m_pul += p;
        if (m_win == 32) begin
          m_dig = (m_pul < 11);
          m_win = 0;
          m_pul = 0;
        end
      end else if (m_run >= 160) begin
        m_dig = 1;
        m_win = 0;
        m_pul = 0;
      end
    end
    @(posedge clk);
    send <= 0;
  endtask : bits
  initial begin
    #2000000;
    err_total++;
    tally_and_finish;
  end
  // ==========================================================================
  // Scenarios
  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1;
    rd(OFF_CTRL);
    chk(d, {30'h0, MODE_DS3});
    rd(4'h8);
    chk({r, d}, {RESP_SLVERR, 32'h0});
    wr(OFF_STATUS, 32'hff);
    check_status;
    bits(159, 0);
    check_status;
    bits(1, 0);
    check_status;
    bits(32, 10);
    check_status;
    bits(32, 11);
    check_status;
    bits(130, 0);
    bits(1, 32);
    bits(150, 0);
    check_status;
    lo <= 1;
    m_ana = 1;
    check_status;
    lo <= 0;
    check_status;
    hi <= 1;
    m_ana = 0;
    check_status;
    hi <= 0;
    wr(OFF_CTRL, {30'h0, MODE_STS1});
    m_mode = 1;
    for (int j = 0; j < 4; j++) begin
      bits(160, 0);
      bits(320, -1);
      check_status;
    end
    wr(OFF_CTRL, {30'h0, MODE_E3});
    m_mode = 2;
    m_dig  = 0;
    m_run  = 0;
    e3 <= 1;
    check_status;
    e3 <= 0;
    lo <= 1;
    bits(200, 0);
    check_status;
    // Code 3 runs the line detectors like DS3; the low comparator is still set
    wr(OFF_CTRL, 32'h3);
    m_mode = 3;
    m_ana  = 1;
    check_status;
    wstrb <= 4'h0;
    wr(OFF_CTRL, {30'h0, MODE_DS3});
    wstrb <= 4'hf;
    rd(OFF_CTRL);
    chk(d, 32'h3);
    tally_and_finish;
  end
endmodule : test_llsd_top
